/* hw/pr_pkg.sv */
package pr_pkg;

  localparam int WORD_W = 16;

  // link clock edges from ready rising to the first word
  localparam logic [3:0] LEAD_PLAIN = 4'h4;
  localparam logic [3:0] LEAD_COMPRESSED = 4'h4;
  localparam logic [3:0] LEAD_ENCRYPTED = 4'h8;
  localparam logic [3:0] LEAD_ENC_COMP = 4'hC;

  // link clock cycle counts of the handshake
  localparam logic [4:0] INIT_CYCLES = 5'h04;
  localparam logic [4:0] DONE_TO_REQ_LOW = 5'h08;
  localparam logic [4:0] SYNC_STAGES = 5'h02;
  localparam logic [4:0] DONE_REQ_CHECK = DONE_TO_REQ_LOW + SYNC_STAGES;
  localparam logic [4:0] DONE_HOLD = 5'h0C;
  localparam logic [4:0] ERROR_HOLD = 5'h0A;
  localparam logic [4:0] REQUEST_GAP = 5'h14;

  // core clock cycles of the region reset pulse
  localparam logic [7:0] REGION_RESET_CYCLES = 8'h10;

  typedef enum logic [1:0] {
    STREAM_PLAIN = 2'h0,
    STREAM_COMPRESSED = 2'h1,
    STREAM_ENCRYPTED = 2'h2,
    STREAM_ENC_COMP = 2'h3
  } stream_kind_e;

  function automatic logic [3:0] lead_cycles(input stream_kind_e kind);
    logic [3:0] lead;
    lead = LEAD_PLAIN;
    case (kind)
      STREAM_PLAIN: lead = LEAD_PLAIN;
      STREAM_COMPRESSED: lead = LEAD_COMPRESSED;
      STREAM_ENCRYPTED: lead = LEAD_ENCRYPTED;
      STREAM_ENC_COMP: lead = LEAD_ENC_COMP;
      default: lead = LEAD_PLAIN;
    endcase
    return lead;
  endfunction : lead_cycles

endpackage : pr_pkg

/* hw/pr_link_if.sv */
`timescale 1ns/10ps
interface pr_link_if;
  logic reconfig_request;
  logic reconfig_ready;
  logic reconfig_done;
  logic reconfig_error;
  logic [pr_pkg::WORD_W-1:0] reconfig_word;
  logic reconfig_clock;
  logic init_complete;
  logic config_memory_crc_fault;
  logic host_location_select;

  modport device (
    input reconfig_request,
    input reconfig_word,
    input reconfig_clock,
    input host_location_select,
    output reconfig_ready,
    output reconfig_done,
    output reconfig_error,
    output init_complete,
    output config_memory_crc_fault
  );

  modport host (
    output reconfig_request,
    output reconfig_word,
    output reconfig_clock,
    output host_location_select,
    input reconfig_ready,
    input reconfig_done,
    input reconfig_error,
    input init_complete,
    input config_memory_crc_fault
  );
endinterface : pr_link_if

/* hw/region_freeze_control_block.sv */
`timescale 1ns/10ps
module region_freeze_control_block #(
  parameter int COUNT_W = 16
) (
  pr_link_if.device link,
  input wire logic i_rst,
  input wire logic i_pin_mode,
  input wire logic i_user_mode,
  input wire logic i_crc_fault,
  input wire pr_pkg::stream_kind_e i_stream_kind,
  input wire logic [COUNT_W-1:0] i_expected_words,
  output logic [pr_pkg::WORD_W-1:0] o_word,
  output logic o_word_valid,
  output logic [COUNT_W-1:0] o_words_taken
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_INIT = 5'b00010,
    ST_READY = 5'b00100,
    ST_DONE = 5'b01000,
    ST_ERROR = 5'b10000
  } cb_state_e;

  cb_state_e st_r, st_nxt;
  logic req_s1_r, req_s2_r, sel_s1_r, sel_s2_r, mode_s1_r, mode_s2_r;
  logic user_s1_r, user_s2_r, crc_s1_r, crc_s2_r;
  logic [4:0] hold_r, hold_nxt;
  logic [3:0] lead_r;
  logic [COUNT_W-1:0] cnt_r;
  logic [pr_pkg::WORD_W-1:0] sum_r;
  logic [pr_pkg::WORD_W-1:0] word_r;
  logic word_valid_r;
  pr_pkg::stream_kind_e kind_s1_r, kind_s2_r;
  logic [COUNT_W-1:0] words_s1_r, words_s2_r;

  wire sel_ok = sel_s2_r == mode_s2_r;
  wire [3:0] lead_last = pr_pkg::lead_cycles(kind_s2_r) - 4'h1;
  wire lead_done = lead_r == lead_last;
  wire cap = (st_r == ST_READY) && lead_done && req_s2_r;
  wire last = cap && (cnt_r == words_s2_r - {{(COUNT_W-1){1'b0}}, 1'b1});
  wire chk_ok = link.reconfig_word == sum_r;

  // everything from the core side is a level, so two flops suffice;
  // stream kind and word count are static straps, so copying the whole word is safe
  always_ff @(posedge link.reconfig_clock or posedge i_rst) begin
    if (i_rst) begin
      {req_s1_r, req_s2_r, sel_s1_r, sel_s2_r, mode_s1_r, mode_s2_r} <= 6'h00;
      {user_s1_r, user_s2_r, crc_s1_r, crc_s2_r} <= 4'h0;
      kind_s1_r <= pr_pkg::STREAM_PLAIN;
      kind_s2_r <= pr_pkg::STREAM_PLAIN;
      words_s1_r <= '0;
      words_s2_r <= '0;
    end else begin
      kind_s1_r <= i_stream_kind;
      kind_s2_r <= kind_s1_r;
      words_s1_r <= i_expected_words;
      words_s2_r <= words_s1_r;
      {req_s2_r, req_s1_r} <= {req_s1_r, link.reconfig_request};
      {sel_s2_r, sel_s1_r} <= {sel_s1_r, link.host_location_select};
      {mode_s2_r, mode_s1_r} <= {mode_s1_r, i_pin_mode};
      {user_s2_r, user_s1_r} <= {user_s1_r, i_user_mode};
      {crc_s2_r, crc_s1_r} <= {crc_s1_r, i_crc_fault};
    end
  end

  // handshake sequencing
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (req_s2_r && sel_ok) st_nxt = ST_INIT;
      ST_INIT: begin
        if (!req_s2_r) st_nxt = ST_ERROR;
        else if (hold_r == pr_pkg::INIT_CYCLES - 5'h01) st_nxt = ST_READY;
      end
      ST_READY: begin
        if (!req_s2_r) st_nxt = ST_ERROR;
        else if (last) st_nxt = chk_ok ? ST_DONE : ST_ERROR;
      end
      ST_DONE: begin
        if (hold_r == pr_pkg::DONE_REQ_CHECK - 5'h01 && req_s2_r) st_nxt = ST_INIT;
        else if (hold_r == pr_pkg::DONE_HOLD - 5'h01) st_nxt = ST_IDLE;
      end
      ST_ERROR: if (hold_r == pr_pkg::ERROR_HOLD - 5'h01) st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  // error hold only counts once the host has let go of its request
  always_comb begin
    hold_nxt = hold_r + 5'h01;
    if (st_nxt != st_r) hold_nxt = 5'h00;
    else if (st_r == ST_ERROR && req_s2_r) hold_nxt = 5'h00;
  end

  always_ff @(posedge link.reconfig_clock or posedge i_rst) begin
    if (i_rst) begin
      st_r <= ST_IDLE;
      hold_r <= 5'h00;
    end else begin
      st_r <= st_nxt;
      hold_r <= hold_nxt;
    end
  end

  // lead count, word count and running check sum
  always_ff @(posedge link.reconfig_clock or posedge i_rst) begin
    if (i_rst) begin
      lead_r <= 4'h0;
      cnt_r <= '0;
      sum_r <= '0;
    end else if (st_r != ST_READY) begin
      lead_r <= 4'h0;
      cnt_r <= '0;
      sum_r <= '0;
    end else if (!lead_done) begin
      lead_r <= lead_r + 4'h1;
    end else if (cap) begin
      cnt_r <= cnt_r + {{(COUNT_W-1){1'b0}}, 1'b1};
      sum_r <= sum_r + link.reconfig_word;
    end
  end

  // captured words to the configuration memory side
  always_ff @(posedge link.reconfig_clock or posedge i_rst) begin
    if (i_rst) begin
      word_r <= '0;
      word_valid_r <= 1'b0;
    end else begin
      word_valid_r <= cap && !last;
      if (cap) word_r <= link.reconfig_word;
    end
  end

  assign link.reconfig_ready = st_r == ST_READY;
  assign link.reconfig_done = st_r == ST_DONE;
  assign link.reconfig_error = st_r == ST_ERROR;
  assign link.init_complete = user_s2_r;
  assign link.config_memory_crc_fault = crc_s2_r;
  assign o_word = word_r;
  assign o_word_valid = word_valid_r;
  assign o_words_taken = cnt_r;
endmodule : region_freeze_control_block

/* hw/pr_host.sv */
`timescale 1ns/10ps
module pr_host #(
  parameter int REGIONS = 2,
  parameter int CLK_HALF_DIV = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  pr_link_if.host link,
  input wire logic i_pin_mode,
  input wire pr_pkg::stream_kind_e i_stream_kind,
  input wire logic i_start,
  input wire logic [REGIONS-1:0] i_region_mask,
  input wire logic i_abort,
  input wire logic i_word_valid,
  input wire logic [pr_pkg::WORD_W-1:0] i_word,
  output logic o_word_ready,
  output logic [REGIONS-1:0] o_region_freeze,
  output logic [REGIONS-1:0] o_region_reset,
  output logic [REGIONS-1:0] o_active_region,
  output logic o_busy,
  output logic o_done,
  output logic o_failed,
  output logic o_crc_fault
);
  typedef enum logic [7:0] {
    H_IDLE = 8'b00000001,
    H_FREEZE = 8'b00000010,
    H_WAIT_INIT = 8'b00000100,
    H_REQUEST = 8'b00001000,
    H_DATA = 8'b00010000,
    H_DRAIN = 8'b00100000,
    H_RELEASE = 8'b01000000,
    H_RESET = 8'b10000000
  } host_state_e;

  localparam logic [7:0] DIV_LAST = 8'(CLK_HALF_DIV - 1);

  host_state_e st_r, st_nxt;
  logic ready_s1_r, ready_s2_r, done_s1_r, done_s2_r, err_s1_r, err_s2_r;
  logic init_s1_r, init_s2_r, crc_s1_r, crc_s2_r;
  logic [7:0] div_r;
  logic clk_r;
  logic [3:0] rise_r;
  logic [4:0] gap_r;
  logic [7:0] rst_cnt_r;
  logic [REGIONS-1:0] pend_r, active_r, freeze_r, done_mask_r;
  logic [pr_pkg::WORD_W-1:0] word_r;
  logic req_r, fail_r, failed_r, finished_r, loc_r;

  // device outputs arrive on the link clock, so each is a two-flop level
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      {ready_s1_r, ready_s2_r, done_s1_r, done_s2_r, err_s1_r, err_s2_r} <= 6'h00;
      {init_s1_r, init_s2_r, crc_s1_r, crc_s2_r} <= 4'h0;
    end else begin
      {ready_s2_r, ready_s1_r} <= {ready_s1_r, link.reconfig_ready};
      {done_s2_r, done_s1_r} <= {done_s1_r, link.reconfig_done};
      {err_s2_r, err_s1_r} <= {err_s1_r, link.reconfig_error};
      {init_s2_r, init_s1_r} <= {init_s1_r, link.init_complete};
      {crc_s2_r, crc_s1_r} <= {crc_s1_r, link.config_memory_crc_fault};
    end
  end

  // link clock divider; the clock parks high when no word is on hand,
  // which keeps the device edge count in step with the words sent
  wire [3:0] lead_last = pr_pkg::lead_cycles(i_stream_kind) - 4'h1;
  wire feed_ok = (st_r == H_DATA) && (rise_r == lead_last);
  wire tick = div_r == DIV_LAST;
  wire stall = tick && clk_r && feed_ok && !i_word_valid;
  wire fall_evt = tick && clk_r && !stall;
  wire rise_evt = tick && !clk_r;
  wire take = fall_evt && feed_ok;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div_r <= 8'h00;
      clk_r <= 1'b0;
    end else if (tick) begin
      if (!stall) begin
        div_r <= 8'h00;
        clk_r <= !clk_r;
      end
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // words change on the falling edge and are taken on the rising one
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      word_r <= '0;
    end else if (take) begin
      word_r <= i_word;
    end
  end

  // rising edges counted since ready was seen
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rise_r <= 4'h0;
    end else if (st_r != H_DATA) begin
      rise_r <= 4'h0;
    end else if (rise_evt && rise_r != lead_last) begin
      rise_r <= rise_r + 4'h1;
    end
  end

  // gap counts rising edges once done and error have both fallen
  wire end_seen = done_s2_r || err_s2_r;
  wire gap_over = rise_evt && (gap_r == pr_pkg::REQUEST_GAP - 5'h01);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      gap_r <= 5'h00;
    end else if (st_r != H_DRAIN || end_seen) begin
      gap_r <= 5'h00;
    end else if (rise_evt) begin
      gap_r <= gap_r + 5'h01;
    end
  end

  // next region is the lowest bit still pending
  wire [REGIONS-1:0] pend_left = pend_r & ~active_r;
  wire [REGIONS-1:0] next_left = pend_left & (~pend_left + {{(REGIONS-1){1'b0}}, 1'b1});
  wire [REGIONS-1:0] first_bit = pend_r & (~pend_r + {{(REGIONS-1){1'b0}}, 1'b1});
  wire rst_over = rst_cnt_r == pr_pkg::REGION_RESET_CYCLES - 8'h01;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      H_IDLE: if (i_start && i_region_mask != '0) st_nxt = H_FREEZE;
      H_FREEZE: st_nxt = H_WAIT_INIT;
      H_WAIT_INIT: if (init_s2_r) st_nxt = H_REQUEST;
      H_REQUEST: begin
        if (i_abort || err_s2_r) st_nxt = H_DRAIN;
        else if (ready_s2_r) st_nxt = H_DATA;
      end
      H_DATA: if (end_seen || i_abort) st_nxt = H_DRAIN;
      H_DRAIN: begin
        if (gap_over) begin
          if (fail_r) st_nxt = H_IDLE;
          else if (pend_left != '0) st_nxt = H_WAIT_INIT;
          else st_nxt = H_RELEASE;
        end
      end
      H_RELEASE: st_nxt = H_RESET;
      H_RESET: if (rst_over) st_nxt = H_IDLE;
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= H_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // request is high only while waiting for ready and streaming
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      req_r <= 1'b0;
    end else begin
      req_r <= (st_nxt == H_REQUEST) || (st_nxt == H_DATA);
    end
  end

  // the failure mark of the cycle in flight
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      fail_r <= 1'b0;
    end else if (st_r == H_WAIT_INIT) begin
      fail_r <= 1'b0;
    end else if ((st_r == H_REQUEST || st_r == H_DATA) && (err_s2_r || i_abort)) begin
      fail_r <= 1'b1;
    end
  end

  // region bookkeeping; freezes stay on after a failure so a retry
  // or a full configuration can follow with the regions still held
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pend_r <= '0;
      active_r <= '0;
      freeze_r <= '0;
      done_mask_r <= '0;
    end else begin
      case (st_r)
        H_IDLE: begin
          if (i_start) begin
            pend_r <= i_region_mask;
            done_mask_r <= '0;
            freeze_r <= freeze_r | i_region_mask;
          end
        end
        H_FREEZE: active_r <= first_bit;
        H_DRAIN: begin
          if (gap_over && !fail_r) begin
            done_mask_r <= done_mask_r | active_r;
            pend_r <= pend_left;
            active_r <= next_left;
          end
        end
        H_RELEASE: freeze_r <= '0;
        default: pend_r <= pend_r;
      endcase
    end
  end

  // region reset pulse length
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_cnt_r <= 8'h00;
    end else if (st_r != H_RESET) begin
      rst_cnt_r <= 8'h00;
    end else begin
      rst_cnt_r <= rst_cnt_r + 8'h01;
    end
  end

  // result flags, cleared by the next start
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      failed_r <= 1'b0;
      finished_r <= 1'b0;
      loc_r <= 1'b0;
    end else begin
      loc_r <= i_pin_mode;
      if (st_r == H_IDLE && i_start) begin
        failed_r <= 1'b0;
        finished_r <= 1'b0;
      end else if (st_r == H_DRAIN && gap_over && fail_r) begin
        failed_r <= 1'b1;
      end else if (st_r == H_RESET && rst_over) begin
        finished_r <= 1'b1;
      end
    end
  end

  assign link.reconfig_request = req_r;
  assign link.reconfig_word = word_r;
  assign link.reconfig_clock = clk_r;
  assign link.host_location_select = loc_r;
  assign o_word_ready = take;
  assign o_region_freeze = freeze_r;
  assign o_region_reset = (st_r == H_RESET) ? done_mask_r : '0;
  assign o_active_region = active_r;
  assign o_busy = st_r != H_IDLE;
  assign o_done = finished_r;
  assign o_failed = failed_r;
  assign o_crc_fault = crc_s2_r;
endmodule : pr_host

/* verification/pr_link_properties.sv */
`timescale 1ns/10ps
module pr_link_properties (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic reconfig_clock,
  input wire logic reconfig_request,
  input wire logic reconfig_ready,
  input wire logic reconfig_done,
  input wire logic reconfig_error
);
  logic [1:0] ends_q_r;
  logic [4:0] tail_r;
  logic [4:0] gap_r;
  logic link_q_r;
  logic [7:0] stall_r;
  wire logic ended_w = |({reconfig_done, reconfig_error} & ~ends_q_r);
  wire logic freed_w = |(~{reconfig_done, reconfig_error} & ends_q_r);

  // link edges since the cycle ended and since its status fell, saturating;
  // a fall is only seen one edge late, so gap_r trails the true count by one
  always_ff @(posedge reconfig_clock or posedge i_rst) begin
    if (i_rst) begin
      ends_q_r <= 2'h0;
      tail_r <= 5'h1F;
      gap_r <= 5'h1F;
    end else begin
      ends_q_r <= {reconfig_done, reconfig_error};
      tail_r <= ended_w ? 5'h00 : tail_r + {4'h0, tail_r != 5'h1F};
      gap_r <= freed_w ? 5'h00 : gap_r + {4'h0, gap_r != 5'h1F};
    end
  end

  // core cycles the link clock has stood still; a park is illegal within 20 link edges of a cycle end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      link_q_r <= 1'b0;
      stall_r <= 8'h00;
    end else begin
      link_q_r <= reconfig_clock;
      stall_r <= (reconfig_clock != link_q_r) ? 8'h00 : stall_r + {7'h00, stall_r != 8'hFF};
    end
  end

  sequence s_cycle_end;
    $rose(reconfig_done) || $rose(reconfig_error);
  endsequence

  sequence s_abort;
    $fell(reconfig_request) && reconfig_ready;
  endsequence

  a_ready_follows: assert property (
    @(posedge reconfig_clock) disable iff (i_rst)
    $rose(reconfig_request) |-> ##[3:10] reconfig_ready) else $error("ready late");
  a_done_ends_ready: assert property (
    @(posedge reconfig_clock) disable iff (i_rst)
    $rose(reconfig_done) |-> !reconfig_ready && !reconfig_error) else $error("done with ready");
  a_error_ends_ready: assert property (
    @(posedge reconfig_clock) disable iff (i_rst)
    $rose(reconfig_error) |-> !reconfig_ready && !reconfig_done) else $error("error with ready");
  a_request_released: assert property (
    @(posedge reconfig_clock) disable iff (i_rst)
    s_cycle_end |-> ##[0:8] !reconfig_request) else $error("request held after end");
  a_done_bounded: assert property (
    @(posedge reconfig_clock) disable iff (i_rst)
    $rose(reconfig_done) |-> ##[1:20] !reconfig_done) else $error("done stuck");
  a_abort_errors: assert property (
    @(posedge reconfig_clock) disable iff (i_rst)
    s_abort |-> ##[1:4] (reconfig_error && !reconfig_ready)) else $error("abort unreported");
  a_clock_runs_on: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    (tail_r < 5'h14) |-> (stall_r < 8'h10)) else $error("link clock stopped early");
  a_request_gap: assert property (
    @(posedge reconfig_clock) disable iff (i_rst)
    (gap_r < 5'h13) |-> !reconfig_request) else $error("request too soon");
endmodule : pr_link_properties

/* verification/partial_reconfig_handshake_test.sv */
`timescale 1ns/10ps
module partial_reconfig_handshake_test;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic pin_mode = 1'b1;
  logic user_mode = 1'b0;
  logic crc_fault = 1'b0;
  pr_pkg::stream_kind_e kind = pr_pkg::STREAM_PLAIN;
  logic start = 1'b0;
  logic [1:0] mask = 2'h0;
  logic abort = 1'b0;
  logic word_valid = 1'b1;
  logic corrupt = 1'b0;
  logic take = 1'b0;
  logic [7:0] idx = 8'h00;
  logic [15:0] tbl [4] = '{16'h1234, 16'h0F0F, 16'hA5A5, 16'h0000};
  logic [15:0] word;
  logic [15:0] dev_word;
  logic dev_valid;
  logic [15:0] dev_taken;
  logic word_ready;
  logic [1:0] freeze;
  logic [1:0] region_rst;
  logic [1:0] active;
  logic busy;
  logic done;
  logic failed;
  logic host_crc;
  int bad_count = 0;
  int total_checks = 0;
  int lead_n;
  int rst_n;
  logic frz_ok;
  logic rst_ok;
  logic [1:0] act_q [$];

  pr_link_if pr_link_if_inst ();
  wire logic rdy_w = pr_link_if_inst.reconfig_ready;
  wire logic lclk_w = pr_link_if_inst.reconfig_clock;

  region_freeze_control_block region_freeze_control_block_inst (
    .link(pr_link_if_inst), .i_rst(i_rst), .i_pin_mode(pin_mode), .i_user_mode(user_mode),
    .i_crc_fault(crc_fault), .i_stream_kind(kind), .i_expected_words(16'h0004),
    .o_word(dev_word), .o_word_valid(dev_valid), .o_words_taken(dev_taken));

  pr_host pr_host_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .link(pr_link_if_inst), .i_pin_mode(pin_mode),
    .i_stream_kind(kind), .i_start(start), .i_region_mask(mask), .i_abort(abort),
    .i_word_valid(word_valid), .i_word(word), .o_word_ready(word_ready),
    .o_region_freeze(freeze), .o_region_reset(region_rst), .o_active_region(active),
    .o_busy(busy), .o_done(done), .o_failed(failed), .o_crc_fault(host_crc));

  pr_link_properties pr_link_properties_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .reconfig_clock(lclk_w),
    .reconfig_request(pr_link_if_inst.reconfig_request), .reconfig_ready(rdy_w),
    .reconfig_done(pr_link_if_inst.reconfig_done),
    .reconfig_error(pr_link_if_inst.reconfig_error));

  // user word source; the check word can be spoiled on purpose
  assign word = (corrupt && idx[1:0] == 2'h3) ? ~tbl[3] : tbl[idx[1:0]];
  always @(negedge i_core_clk) take = word_ready && word_valid;
  always @(posedge i_core_clk) if (take) #1 idx = idx + 8'h01;

  initial begin
    forever #50 i_core_clk = ~i_core_clk;
  end

  task automatic tick();
    @(posedge i_core_clk);
    #1;
  endtask : tick

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // one host job; records lead, region order, freezes and reset pulse
  task automatic run(input logic [1:0] m);
    logic rdy_q;
    logic lclk_q;
    logic lead_on;
    int n;
    lead_n = 0;
    rst_n = 0;
    frz_ok = 1'b1;
    rst_ok = 1'b1;
    act_q = {};
    idx = 8'h00;
    rdy_q = 1'b0;
    lclk_q = lclk_w;
    lead_on = 1'b0;
    mask = m;
    start = 1'b1;
    tick();
    start = 1'b0;
    for (n = 0; n < 6000 && busy !== 1'b0; n++) begin
      tick();
      if (lclk_w && !lclk_q && lead_on) begin
        lead_n++;
        lead_on = !dev_valid;
      end
      if (rdy_w && !rdy_q) begin
        act_q.push_back(active);
        frz_ok = frz_ok && (freeze === m);
        lead_on = lead_on || (act_q.size() == 1);
      end
      rdy_q = rdy_w;
      lclk_q = lclk_w;
      if (region_rst !== 2'h0) begin
        rst_n++;
        rst_ok = rst_ok && region_rst === m && freeze === 2'h0;
      end
    end
    if (n == 6000) begin
      check(1'b0, "host hung");
      wrap_up();
    end
  endtask : run

  task automatic t_user_gate();
    crc_fault = 1'b1;
    fork
      run(2'h1);
      begin
        repeat (200) tick();
        check(pr_link_if_inst.reconfig_request === 1'b0, "request before user mode");
        user_mode = 1'b1;
      end
    join
    check(done === 1'b1 && host_crc === 1'b1, "crc fault not mirrored");
    check(pr_link_if_inst.host_location_select === pin_mode, "select not tied");
    crc_fault = 1'b0;
  endtask : t_user_gate

  task automatic t_lead_kinds();
    int want [4] = '{4, 4, 8, 12};
    for (int k = 0; k < 4; k++) begin
      kind = pr_pkg::stream_kind_e'(k);
      run(2'h1);
      check(lead_n == want[k], "lead to first word");
      check(done === 1'b1 && dev_word === tbl[3], "stream not accepted");
      check(rst_n == 16 && rst_ok, "region reset pulse");
    end
    kind = pr_pkg::STREAM_PLAIN;
  endtask : t_lead_kinds

  task automatic t_two_regions();
    run(2'h3);
    check(act_q.size() == 2 && act_q[0] === 2'h1 && act_q[1] === 2'h2, "region order");
    check(frz_ok === 1'b1, "freeze missing at ready");
    check(rst_ok === 1'b1 && freeze === 2'h0 && rst_n == 16, "freeze kept");
  endtask : t_two_regions

  task automatic t_corrupt_retry();
    corrupt = 1'b1;
    run(2'h1);
    check(failed === 1'b1 && done === 1'b0 && freeze === 2'h1, "bad stream passed");
    corrupt = 1'b0;
    run(2'h1);
    check(done === 1'b1 && freeze === 2'h0, "retry failed");
  endtask : t_corrupt_retry

  task automatic t_pause_abort();
    logic lvl;
    logic [15:0] seen;
    fork
      run(2'h1);
      begin
        for (int n = 0; n < 3000 && idx == 8'h00; n++) tick();
        word_valid = 1'b0;
        repeat (32) tick();
        lvl = lclk_w;
        seen = dev_taken;
        repeat (32) tick();
        check(lclk_w === lvl && dev_taken === seen && seen !== 16'h0, "clock ran");
        abort = 1'b1;
      end
    join
    check(failed === 1'b1 && done === 1'b0, "abort not reported");
    abort = 1'b0;
    word_valid = 1'b1;
  endtask : t_pause_abort

  // both ends reset asynchronously, so a short reset covers the link side too
  initial begin
    tbl[3] = tbl[0] + tbl[1] + tbl[2];
    repeat (3) tick();
    i_rst = 1'b0;
    repeat (2) tick();
    t_user_gate();
    t_lead_kinds();
    t_two_regions();
    t_corrupt_retry();
    t_pause_abort();
    wrap_up();
  end
endmodule : partial_reconfig_handshake_test
